/* File: design/uesb_defs.vh */
// Constants for the unit error status bank: offsets, fields, resets.
// Assumes an AXI4-Lite master with 32-bit data and a 40 MHz aclk.
`ifndef UESB_DEFS_VH
`define UESB_DEFS_VH

// ----------------------------------------------------------------------
// Register indices and byte addresses
// ----------------------------------------------------------------------
`define UESB_IDX_MEM 16'h0001
`define UESB_IDX_CFGA 16'h0002
`define UESB_IDX_CFGB 16'h0003
`define UESB_IDX_LINK 16'h0004
`define UESB_ADDR_MEM 8'h04
`define UESB_ADDR_CFGA 8'h08
`define UESB_ADDR_CFGB 8'h0c
`define UESB_ADDR_LINK 8'h10
`define UESB_ADDR_TOP 8'h20
`define UESB_ADDR_IRQ_STAT 8'h24
`define UESB_ADDR_IRQ_EN 8'h28
`define UESB_ADDR_IRQ_CLR 8'h2c
`define UESB_ADDR_COUNT 8'h30

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define UESB_MEM_NVM 4
`define UESB_MEM_CAL 5
`define UESB_MEM_SET 6
`define UESB_MEM_REG 8
`define UESB_MEM_MODEL 9
`define UESB_MEM_MISMATCH 12
`define UESB_CFGA_UNKNOWN 0
`define UESB_CFGA_TOO_MANY 2
`define UESB_CFGA_FAIL 3
`define UESB_CFGA_SILENT 4
`define UESB_TOP_MEM 0
`define UESB_TOP_CFG 1
`define UESB_TOP_LINK 4
`define UESB_IRQ_W 4

// ----------------------------------------------------------------------
// Values
// ----------------------------------------------------------------------
`define UESB_MAX_UNITS 4'h9
`define UESB_ZERO16 16'h0000
`define UESB_ZERO32 32'h0000_0000
`define UESB_RESP_OKAY 2'h0
`define UESB_RESP_SLVERR 2'h2

`endif

/* File: design/uesb_sync.v */
// Two-flop synchroniser for a bus of asynchronous fault inputs.
// Assumes inputs come from outside the aclk domain.
`timescale 1ns/1ps
`default_nettype none

module uesb_sync #(
  parameter W = 8
) (
  input wire aclk,
  input wire aresetn,
  input wire [W-1:0] d,
  output wire [W-1:0] q
);

  reg [W-1:0] meta;
  reg [W-1:0] stable;

  // First stage feeds only the second stage
  always @(posedge aclk) begin
    if (!aresetn) begin
      meta <= {W{1'b0}};
      stable <= {W{1'b0}};
    end else begin
      meta <= d;
      stable <= meta;
    end
  end

  assign q = stable;

endmodule // uesb_sync

`default_nettype wire

/* File: design/uesb_bank.v */
// Unit error status bank: fault status words behind an AXI4-Lite slave.
// Assumes fault detectors and the expansion link present level inputs
// from outside aclk; all are synchronised before use.
//
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "uesb_defs.vh"

module uesb_bank (
  input wire aclk,
  input wire aresetn,
  // Fault detector levels
  input wire mem_nvm_fault,
  input wire mem_cal_fault,
  input wire mem_set_fault,
  input wire mem_reg_fault,
  input wire mem_model_fault,
  input wire mem_mismatch_fault,
  input wire unit_unknown_type,
  input wire [3:0] unit_count,
  input wire [7:0] unit_comm_fault,
  input wire [7:0] unit_registered,
  input wire [7:0] unit_responding,
  input wire [7:0] unit_link_fault,
  // AXI4-Lite slave
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Summary and interrupt
  output reg [15:0] top_status,
  output wire irq
);

  // --------------------------------------------------------------------
  // Input synchronisation
  // --------------------------------------------------------------------
  localparam SW = 43;
  wire [SW-1:0] raw_in;
  wire [SW-1:0] syn;
  assign raw_in = {mem_nvm_fault, mem_cal_fault, mem_set_fault,
    mem_reg_fault, mem_model_fault, mem_mismatch_fault,
    unit_unknown_type, unit_count, unit_comm_fault, unit_registered,
    unit_responding, unit_link_fault};

  uesb_sync #(.W(SW)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d(raw_in),
    .q(syn)
  );

  wire s_nvm = syn[42];
  wire s_cal = syn[41];
  wire s_set = syn[40];
  wire s_reg = syn[39];
  wire s_model = syn[38];
  wire s_mism = syn[37];
  wire s_unknown = syn[36];
  wire [3:0] s_count = syn[35:32];
  wire [7:0] s_comm = syn[31:24];
  wire [7:0] s_regd = syn[23:16];
  wire [7:0] s_resp = syn[15:8];
  wire [7:0] s_link = syn[7:0];

  // --------------------------------------------------------------------
  // Status words
  // --------------------------------------------------------------------
  reg [15:0] mem_fault_status;
  reg [15:0] config_fault_status_a;
  reg [15:0] config_fault_status_b;
  reg [15:0] unit_link_error_status;
  reg [15:0] next_mem;
  reg [15:0] next_cfga;
  reg [15:0] next_cfgb;
  reg [15:0] next_link;
  reg [15:0] next_top;

  // Build each word; unlisted positions stay zero
  always @* begin
    next_mem = `UESB_ZERO16;
    next_cfga = `UESB_ZERO16;
    next_cfgb = `UESB_ZERO16;
    next_link = `UESB_ZERO16;
    next_top = `UESB_ZERO16;
    next_mem[`UESB_MEM_NVM] = s_nvm;
    next_mem[`UESB_MEM_CAL] = s_cal;
    next_mem[`UESB_MEM_SET] = s_set;
    next_mem[`UESB_MEM_REG] = s_reg;
    next_mem[`UESB_MEM_MODEL] = s_model;
    next_mem[`UESB_MEM_MISMATCH] = s_mism;
    next_cfga[`UESB_CFGA_UNKNOWN] = s_unknown;
    next_cfga[`UESB_CFGA_TOO_MANY] = (s_count > `UESB_MAX_UNITS);
    next_cfga[`UESB_CFGA_FAIL] = |s_comm;
    next_cfga[`UESB_CFGA_SILENT] = |(s_regd & ~s_resp);
    next_cfgb[7:0] = s_comm;
    next_link[7:0] = s_link;
    next_top[`UESB_TOP_MEM] = |next_mem;
    next_top[`UESB_TOP_CFG] = (|next_cfga) | (|next_cfgb);
    next_top[`UESB_TOP_LINK] = |next_link;
  end

  // Status words track the synchronised faults, one cycle behind
  always @(posedge aclk) begin
    if (!aresetn) begin
      mem_fault_status <= `UESB_ZERO16;
      config_fault_status_a <= `UESB_ZERO16;
      config_fault_status_b <= `UESB_ZERO16;
      unit_link_error_status <= `UESB_ZERO16;
      top_status <= `UESB_ZERO16;
    end else begin
      mem_fault_status <= next_mem;
      config_fault_status_a <= next_cfga;
      config_fault_status_b <= next_cfgb;
      unit_link_error_status <= next_link;
      top_status <= next_top;
    end
  end

  // --------------------------------------------------------------------
  // Interrupt: sticky on rising summary of each word
  // --------------------------------------------------------------------
  reg [3:0] irq_status;
  reg [3:0] irq_enable;
  reg [3:0] prev_any;
  wire [3:0] any_now;
  wire [3:0] irq_event;
  wire wr_fire;
  reg [3:0] irq_clr;

  assign any_now = {|unit_link_error_status, |config_fault_status_b,
    |config_fault_status_a, |mem_fault_status};
  assign irq_event = any_now & ~prev_any;
  assign irq = |(irq_status & irq_enable);

  // Set wins over a clear in the same cycle
  always @(posedge aclk) begin
    if (!aresetn) begin
      prev_any <= 4'h0;
      irq_status <= 4'h0;
    end else begin
      prev_any <= any_now;
      irq_status <= (irq_status & ~irq_clr) | irq_event;
    end
  end

  // --------------------------------------------------------------------
  // AXI4-Lite write path
  // --------------------------------------------------------------------
  reg aw_held;
  reg w_held;
  reg [7:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;

  // Each channel is taken independently and held until the response
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign wr_fire = aw_held && w_held && !s_axi_bvalid;

  // Decode write address; status words are read-only
  function wr_ok;
    input [7:0] a;
    begin
      wr_ok = (a == `UESB_ADDR_IRQ_EN) || (a == `UESB_ADDR_IRQ_CLR);
    end
  endfunction

  // Clear pulse from the write-only clear register
  always @* begin
    irq_clr = 4'h0;
    if (wr_fire && aw_addr == `UESB_ADDR_IRQ_CLR && w_strb[0])
      irq_clr = w_data[`UESB_IRQ_W-1:0];
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= `UESB_ZERO32;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `UESB_RESP_OKAY;
      irq_enable <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok(aw_addr) ? `UESB_RESP_OKAY
                                      : `UESB_RESP_SLVERR;
        if (aw_addr == `UESB_ADDR_IRQ_EN && w_strb[0])
          irq_enable <= w_data[`UESB_IRQ_W-1:0];
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------
  // AXI4-Lite read path
  // --------------------------------------------------------------------
  reg [31:0] rd_word;
  reg rd_hit;

  assign s_axi_arready = !s_axi_rvalid;

  // narrow words zero-extended, unused bits zero
  always @* begin
    rd_word = `UESB_ZERO32;
    rd_hit = 1'b1;
    case ({s_axi_araddr[7:2], 2'b00})
      `UESB_ADDR_MEM: rd_word = {16'h0000, mem_fault_status};
      `UESB_ADDR_CFGA: rd_word = {16'h0000, config_fault_status_a};
      `UESB_ADDR_CFGB: rd_word = {16'h0000, config_fault_status_b};
      `UESB_ADDR_LINK: rd_word = {16'h0000, unit_link_error_status};
      `UESB_ADDR_TOP: rd_word = {16'h0000, top_status};
      `UESB_ADDR_IRQ_STAT: rd_word = {28'h0000000, irq_status};
      `UESB_ADDR_IRQ_EN: rd_word = {28'h0000000, irq_enable};
      `UESB_ADDR_IRQ_CLR: rd_word = `UESB_ZERO32;
      default: rd_hit = 1'b0;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= `UESB_ZERO32;
      s_axi_rresp <= `UESB_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_hit ? `UESB_RESP_OKAY : `UESB_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // uesb_bank

`default_nettype wire

/* File: dv/uesb_units.sv */
// Model of the chain of expansion units on the internal link.
// Assumes the bench picks which units exist, stay silent or fail.
`timescale 1ns/1ps
`default_nettype none
module uesb_units (
  input wire logic aclk,
  input wire logic [7:0] pres,
  input wire logic [7:0] mute,
  input wire logic [7:0] comm,
  input wire logic [7:0] link,
  output logic [7:0] unit_registered,
  output logic [7:0] unit_responding,
  output logic [7:0] unit_comm_fault,
  output logic [7:0] unit_link_fault
);
  logic [7:0] tog = 8'h00;
  // Empty slots have no driver, so their answer line wanders
  always @(posedge aclk) tog <= ~tog;
  // Units report their own faults as levels
  assign unit_registered = pres;
  assign unit_responding = (pres & ~mute) | (~pres & tog);
  assign unit_comm_fault = comm;
  assign unit_link_fault = link;
endmodule // uesb_units
`default_nettype wire

/* File: dv/uesb_bank_monitor.sv */
// Checker on the ports of the unit error status bank.
// Assumes a bind to uesb_bank and the single aclk domain.
`timescale 1ns/1ps
`default_nettype none
`include "uesb_defs.vh"
module uesb_bank_monitor (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] unit_comm_fault,
  input wire logic [7:0] unit_link_fault,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [15:0] top_status
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ------
  // Bus handshake, read data and summary bits
  // ------
  sequence s_ar_take; s_axi_arvalid && s_axi_arready; endsequence
  sequence s_r_stall; s_axi_rvalid && !s_axi_rready; endsequence
  a_rd_answer: assert property (s_ar_take |=> s_axi_rvalid)
    else $error("read not answered next cycle");
  a_rd_hold: assert property (s_r_stall |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped or changed");
  a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  a_aw_block: assert property (s_axi_bvalid |->
    !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  a_rd_upper: assert property (s_axi_rvalid |->
    s_axi_rdata[31:16] == 16'h0000) else $error("upper read half not zero");
  a_rd_err_zero: assert property (s_axi_rvalid &&
    s_axi_rresp == `UESB_RESP_SLVERR |-> s_axi_rdata == 32'h0000_0000)
    else $error("refused read carries data");
  a_top_unused: assert property (top_status[15:5] == 11'h000 &&
    top_status[3:2] == 2'h0) else $error("unused summary bit set");
  a_top_cfg: assert property ((unit_comm_fault != 8'h00)[*7] |->
    top_status[1]) else $error("config summary missing");
  a_top_link: assert property ((unit_link_fault != 8'h00)[*7] |->
    top_status[4]) else $error("link summary missing");
  a_top_link_off: assert property ((unit_link_fault == 8'h00)[*7] |->
    !top_status[4]) else $error("link summary stuck");
endmodule // uesb_bank_monitor
`default_nettype wire

/* File: dv/uesb_bank_test.sv */
// Self-checking bench for the unit error status bank.
// Assumes the unit chain model and the port checker beside it.
`timescale 1ns/1ps
`default_nettype none
`include "uesb_defs.vh"
`define CHK(n, e, g) begin cmp_count++; if ((e) !== (g)) begin failures++; \
  $display("[FAIL] %s exp %h got %h", n, e, g); end end
module uesb_bank_test;
  logic aclk = 1'b0, aresetn = 1'b0, unit_unknown_type = 1'b0;
  logic [5:0] mf = 6'h00;
  logic [3:0] unit_count = 4'h0, s_axi_wstrb = 4'hf;
  logic [7:0] pres = 8'h00, mute = 8'h00, comm = 8'h00, link = 8'h00;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire s_axi_rvalid, irq;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [15:0] top_status;
  wire [7:0] unit_registered, unit_responding;
  wire [7:0] unit_comm_fault, unit_link_fault;
  int failures = 0, cmp_count = 0, cyc = 0, i;
  logic [33:0] rq[$];
  logic [1:0] wq[$];
  logic [33:0] ex;
  logic [1:0] eb;
  logic [15:0] ea, em, et;
  uesb_bank uesb_bank_i (.mem_nvm_fault(mf[0]), .mem_cal_fault(mf[1]),
    .mem_set_fault(mf[2]), .mem_reg_fault(mf[3]), .mem_model_fault(mf[4]),
    .mem_mismatch_fault(mf[5]), .*);
  uesb_units uesb_units_i (.*);
  initial forever #12.5 aclk = ~aclk;
  // ------
  // Bus master and result watcher
  // ------
  task automatic wr(input [7:0] a, input [31:0] d, input [1:0] r);
    bit ta, tw;
    ta = 1;
    tw = 1;
    wq.push_back(r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) ta = 0;
      if (s_axi_wready) tw = 0;
      s_axi_awvalid <= ta;
      s_axi_wvalid <= tw;
    end while (ta || tw);
    while (!s_axi_bvalid) @(posedge aclk);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input [7:0] a, input [33:0] e);
    int n;
    n = $urandom % 3;
    rq.push_back(e);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    // Hold off the answer now and then so a stalled read is exercised
    repeat (n) @(posedge aclk);
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask
  // Each answer is matched against the oldest note
  always @(posedge aclk) begin
    if (s_axi_rvalid && s_axi_rready) begin
      ex = rq.pop_front();
      `CHK("read", ex, {s_axi_rresp, s_axi_rdata})
    end
    if (s_axi_bvalid && s_axi_bready) begin
      eb = wq.pop_front();
      `CHK("bresp", eb, s_axi_bresp)
    end
  end
  // Expected words follow from the inputs now held
  task automatic check_all();
    em = {3'h0, mf[5], 2'h0, mf[4:3], 1'b0, mf[2:0], 4'h0};
    ea = {11'h0, |(pres & mute), |comm, unit_count > 4'h9, 1'b0,
      unit_unknown_type};
    rd(`UESB_ADDR_MEM, {18'h0, em});
    rd(`UESB_ADDR_CFGA, {18'h0, ea});
    rd(`UESB_ADDR_CFGB, {26'h0, comm});
    rd(`UESB_ADDR_LINK, {26'h0, link});
    et = {11'h0, |link, 2'h0, |(ea | comm), |em};
    rd(`UESB_ADDR_TOP, {18'h0, et});
    @(negedge aclk) `CHK("top port", et, top_status)
  endtask
  task automatic test_done();
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Hang guard
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      failures++;
      test_done();
    end
  end
  // ------
  // Main sequence
  // ------
  initial begin
    void'($urandom(57));
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    check_all();
    // First two passes sit on the unit count boundary
    for (i = 0; i < 24; i++) begin
      @(posedge aclk);
      unit_count <= (i < 2) ? 4'(9 + i) : 4'($urandom);
      mf <= 6'($urandom);
      unit_unknown_type <= 1'($urandom);
      pres <= 8'($urandom);
      mute <= 8'($urandom & $urandom);
      comm <= 8'($urandom & $urandom);
      link <= 8'($urandom & $urandom);
      repeat (6) @(posedge aclk);
      check_all();
    end
    wr(`UESB_ADDR_MEM, 32'hffff_ffff, `UESB_RESP_SLVERR);
    wr(8'h34, 32'h0000_0001, `UESB_RESP_SLVERR);
    rd(8'h3c, {`UESB_RESP_SLVERR, 32'h0000_0000});
    check_all();
    @(posedge aclk);
    {mf, unit_unknown_type, unit_count} <= 11'h000;
    {pres, mute, comm, link} <= 32'h0000_0000;
    repeat (6) @(posedge aclk);
    wr(`UESB_ADDR_IRQ_CLR, 32'h0000_000f, `UESB_RESP_OKAY);
    wr(`UESB_ADDR_IRQ_EN, 32'h0000_000f, `UESB_RESP_OKAY);
    rd(`UESB_ADDR_IRQ_EN, 34'h0_0000_000f);
    rd(`UESB_ADDR_IRQ_CLR, 34'h0_0000_0000);
    @(negedge aclk) `CHK("irq idle", 1'b0, irq)
    @(posedge aclk) link <= 8'h01;
    repeat (6) @(posedge aclk);
    rd(`UESB_ADDR_IRQ_STAT, 34'h0_0000_0008);
    @(negedge aclk) `CHK("irq raised", 1'b1, irq)
    // Enable write without its low byte lane leaves the mask alone
    @(posedge aclk) s_axi_wstrb <= 4'he;
    wr(`UESB_ADDR_IRQ_EN, 32'h0000_0000, `UESB_RESP_OKAY);
    @(negedge aclk) `CHK("irq kept", 1'b1, irq)
    @(posedge aclk) s_axi_wstrb <= 4'hf;
    wr(`UESB_ADDR_IRQ_EN, 32'h0000_0000, `UESB_RESP_OKAY);
    @(negedge aclk) `CHK("irq masked", 1'b0, irq)
    wr(`UESB_ADDR_IRQ_EN, 32'h0000_000f, `UESB_RESP_OKAY);
    wr(`UESB_ADDR_IRQ_CLR, 32'h0000_0008, `UESB_RESP_OKAY);
    @(negedge aclk) `CHK("irq cleared", 1'b0, irq)
    rd(`UESB_ADDR_IRQ_STAT, 34'h0_0000_0000);
    // Reset in mid-run with a link fault standing clears every word
    @(posedge aclk) aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    @(negedge aclk) `CHK("reset top", 16'h0000, top_status)
    `CHK("reset irq", 1'b0, irq)
    @(posedge aclk) aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
    rd(`UESB_ADDR_IRQ_EN, 34'h0_0000_0000);
    check_all();
    test_done();
  end
endmodule // uesb_bank_test
bind uesb_bank uesb_bank_monitor uesb_bank_monitor_i (.*);
`default_nettype wire
